// ### src/itd_convert.sv
`timescale 1ns/1ps
`include "itd_defines.svh"

// ----------------------------------------------------------------------------
// integer to double converter
// ----------------------------------------------------------------------------
// Overview of operation
// - The sign comes from the top source bit, the whole source loads as the fraction, exponent starts at 63.
// - A zero source gives an all-zero result, clears rounded and inexact, and reports positive zero.
// - A negative source is negated (invert plus one) before normalizing.
// - While the leading fraction bit is zero, shift left by one and decrement the exponent.
// - Kept lsb is fraction bit 52, guard 53, round 54, sticky the OR of 55 to 63 (bit 0 leading).
// - Nearest-even mode increments when guard is set and any of lsb, round or sticky is set.
// - Round-up mode increments a positive value when guard, round or sticky is set.
// - Round-down mode increments a negative value when guard, round or sticky is set.
// - The increment adds into the top 53 bits and a carry out raises the exponent by one.
// - Rounded bit takes the increment, inexact bit the OR of guard, round and sticky.
// - The inexact bit is ORed into the sticky inexact bit, which the converter never clears.
// - A nonzero result is classed negative normal for sign one, positive normal for sign zero.
// - Result is sign, exponent plus 1023, then the 52 fraction bits below the leading one.
module itd_convert (
  input wire logic clk, // core clock, 125 MHz
  input wire logic sys_rst, // asynchronous reset, active high
  input wire itd_pkg::itd_addr_t reg_addr, // register byte address
  input wire itd_pkg::itd_word_t reg_wdata, // register write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output itd_pkg::itd_word_t reg_rdata, // read data, cycle after strobe
  output logic irq // level interrupt
);
  import itd_pkg::*;

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  itd_state_e state_r;
  itd_state_e state_nxt;
  itd_frac_t src_r;
  itd_frac_t src_nxt;
  itd_frac_t frac_r;
  itd_frac_t frac_nxt;
  itd_exp_t exp_r;
  itd_exp_t exp_nxt;
  logic sign_r;
  logic sign_nxt;
  itd_frac_t res_r;
  itd_frac_t res_nxt;
  itd_mode_t mode_r;
  itd_mode_t mode_nxt;
  logic rounded_r;
  logic rounded_nxt;
  logic inexact_r;
  logic inexact_nxt;
  logic sticky_r;
  logic sticky_nxt;
  itd_class_t rclass_r;
  itd_class_t rclass_nxt;
  logic [1:0] int_stat_r;
  logic [1:0] int_stat_nxt;
  logic [1:0] int_mask_r;
  logic [1:0] int_mask_nxt;

  // --------------------------------------------------------------------------
  // register decode
  // --------------------------------------------------------------------------
  logic sel_src_lo;
  logic sel_src_hi;
  logic sel_cmd;
  logic sel_fstat;
  logic sel_res_lo;
  logic sel_res_hi;
  logic sel_status;
  logic sel_int_stat;
  logic sel_int_mask;
  logic busy;
  logic start_req;
  itd_word_t fstat_word;
  itd_word_t rd_mux;

  // address compare for each register
  assign sel_src_lo = (reg_addr == `ITD_OFS_SRC_LO);
  assign sel_src_hi = (reg_addr == `ITD_OFS_SRC_HI);
  assign sel_cmd = (reg_addr == `ITD_OFS_CMD);
  assign sel_fstat = (reg_addr == `ITD_OFS_FSTAT);
  assign sel_res_lo = (reg_addr == `ITD_OFS_RES_LO);
  assign sel_res_hi = (reg_addr == `ITD_OFS_RES_HI);
  assign sel_status = (reg_addr == `ITD_OFS_STATUS);
  assign sel_int_stat = (reg_addr == `ITD_OFS_INT_STAT);
  assign sel_int_mask = (reg_addr == `ITD_OFS_INT_MASK);

  // a start is only taken while idle
  assign busy = (state_r != ST_IDLE);
  assign start_req = reg_wr & sel_cmd & reg_wdata[`ITD_CMD_START] & ~busy;

  // --------------------------------------------------------------------------
  // datapath helpers
  // --------------------------------------------------------------------------
  itd_frac_t norm_frac;
  itd_exp_t norm_exp;
  logic norm_done;
  logic rnd_inc;
  logic [52:0] rnd_kept;
  logic rnd_carry;
  logic rnd_inx;
  logic src_zero;
  itd_exp_t exp_rnd;
  logic [10:0] exp_biased;
  logic fin_zero;
  logic fin_round;
  logic [1:0] int_evt;

  // one normalizing shift per cycle
  itd_norm_step u_norm (
    .frac_in (frac_r),
    .exp_in (exp_r),
    .frac_out (norm_frac),
    .exp_out (norm_exp),
    .normalized (norm_done)
  );

  // rounding under the mode held in the control register
  itd_round u_round (
    .frac (frac_r),
    .sign (sign_r),
    .mode (mode_r),
    .inc (rnd_inc),
    .kept (rnd_kept),
    .carry (rnd_carry),
    .inexact (rnd_inx)
  );

  // finishing cycles and the rounded exponent
  assign src_zero = (src_r == 64'h0);
  assign fin_zero = (state_r == ST_LOAD) & src_zero;
  assign fin_round = (state_r == ST_ROUND);
  assign exp_rnd = exp_r + {6'h00, rnd_carry};
  assign exp_biased = {4'h0, exp_rnd} + `ITD_EXP_BIAS;

  // --------------------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------------------
  // load, negate, normalize, round
  always_comb
  begin
    state_nxt = state_r;
    frac_nxt = frac_r;
    exp_nxt = exp_r;
    sign_nxt = sign_r;
    case (state_r)
      ST_IDLE:
      begin
        if (start_req)
          state_nxt = ST_LOAD;
      end
      ST_LOAD:
      begin
        sign_nxt = src_r[63];
        frac_nxt = src_r;
        exp_nxt = `ITD_EXP_INIT;
        state_nxt = src_zero ? ST_IDLE : ST_NEG;
      end
      ST_NEG:
      begin
        if (sign_r)
          frac_nxt = ~frac_r + 64'h1;
        state_nxt = ST_NORM;
      end
      ST_NORM:
      begin
        frac_nxt = norm_frac;
        exp_nxt = norm_exp;
        if (norm_done)
          state_nxt = ST_ROUND;
      end
      ST_ROUND:
      begin
        state_nxt = ST_IDLE;
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // results and status fields
  // --------------------------------------------------------------------------
  // packed result, written on finish only
  assign res_nxt = fin_zero ? 64'h0 :
                   fin_round ? {sign_r, exp_biased, rnd_kept[51:0]} : res_r;

  // rounded and inexact bits follow the last conversion
  assign rounded_nxt = fin_zero ? 1'b0 : fin_round ? rnd_inc : rounded_r;
  assign inexact_nxt = fin_zero ? 1'b0 : fin_round ? rnd_inx : inexact_r;

  // result class
  assign rclass_nxt = fin_zero ? `ITD_CLASS_PZERO :
                      fin_round ? (sign_r ? `ITD_CLASS_NNORM : `ITD_CLASS_PNORM) : rclass_r;

  // sticky inexact: software may write it, a new inexact wins
  assign sticky_nxt = ((reg_wr & sel_fstat) ? reg_wdata[`ITD_FSTAT_STICKY] : sticky_r)
                      | (fin_round & rnd_inx);

  // rounding control written by software
  assign mode_nxt = (reg_wr & sel_fstat) ? reg_wdata[`ITD_FSTAT_RND_HI:`ITD_FSTAT_RND_LO] : mode_r;

  // source words
  assign src_nxt = {(reg_wr & sel_src_hi) ? reg_wdata : src_r[63:32],
                    (reg_wr & sel_src_lo) ? reg_wdata : src_r[31:0]};

  // --------------------------------------------------------------------------
  // interrupts
  // --------------------------------------------------------------------------
  // done and inexact events; a set in the clearing cycle wins
  assign int_evt = {fin_round & rnd_inx, fin_zero | fin_round};
  assign int_stat_nxt = (int_stat_r & ~((reg_wr & sel_int_stat) ? reg_wdata[1:0] : 2'h0)) | int_evt;
  assign int_mask_nxt = (reg_wr & sel_int_mask) ? reg_wdata[1:0] : int_mask_r;

  // --------------------------------------------------------------------------
  // read mux
  // --------------------------------------------------------------------------
  assign fstat_word = {22'h0, rclass_r, sticky_r, inexact_r, rounded_r, mode_r};
  assign rd_mux = sel_src_lo ? src_r[31:0] :
                  sel_src_hi ? src_r[63:32] :
                  sel_fstat ? fstat_word :
                  sel_res_lo ? res_r[31:0] :
                  sel_res_hi ? res_r[63:32] :
                  sel_status ? {31'h0, busy} :
                  sel_int_stat ? {30'h0, int_stat_r} :
                  sel_int_mask ? {30'h0, int_mask_r} : 32'h0;

  // --------------------------------------------------------------------------
  // flip-flops
  // --------------------------------------------------------------------------
  // sequencer and working registers
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_r <= ST_IDLE;
      frac_r <= 64'h0;
      exp_r <= 7'h00;
      sign_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      frac_r <= frac_nxt;
      exp_r <= exp_nxt;
      sign_r <= sign_nxt;
    end
  end

  // source and result
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      src_r <= 64'h0;
      res_r <= 64'h0;
    end
    else
    begin
      src_r <= src_nxt;
      res_r <= res_nxt;
    end
  end

  // status and control fields
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mode_r <= `ITD_RND_RST;
      rounded_r <= 1'b0;
      inexact_r <= 1'b0;
      sticky_r <= 1'b0;
      rclass_r <= `ITD_CLASS_RST;
    end
    else
    begin
      mode_r <= mode_nxt;
      rounded_r <= rounded_nxt;
      inexact_r <= inexact_nxt;
      sticky_r <= sticky_nxt;
      rclass_r <= rclass_nxt;
    end
  end

  // interrupt state and bus outputs
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      int_stat_r <= 2'h0;
      int_mask_r <= `ITD_INT_MASK_RST;
      irq <= 1'b0;
      reg_rdata <= 32'h0;
    end
    else
    begin
      int_stat_r <= int_stat_nxt;
      int_mask_r <= int_mask_nxt;
      irq <= |(int_stat_nxt & int_mask_nxt);
      reg_rdata <= reg_rd ? rd_mux : 32'h0;
    end
  end

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // load sets sign, fraction and starting exponent
  AST_LOAD_INIT: assert property ((state_r == ST_LOAD) && !src_zero |=>
    (state_r == ST_NEG) && (exp_r == 7'h3f) && (sign_r == $past(src_r[63])) && (frac_r == $past(src_r)))
    else $error("load did not set sign, fraction and exponent");

  // zero source takes the short path
  AST_ZERO_PATH: assert property ((state_r == ST_LOAD) && src_zero |=>
    (state_r == ST_IDLE) && (res_r == 64'h0) && !rounded_r && !inexact_r && (rclass_r == 5'h02))
    else $error("zero source not handled");

  // negative values are negated once
  AST_NEGATE: assert property ((state_r == ST_NEG) && sign_r |=>
    (frac_r == ~$past(frac_r) + 64'h1) && (state_r == ST_NORM))
    else $error("negation wrong");

  // each normalizing cycle shifts one place
  AST_NORM_SHIFT: assert property ((state_r == ST_NORM) && !frac_r[63] |=>
    (frac_r == {$past(frac_r[62:0]), 1'b0}) && (exp_r == $past(exp_r) - 7'h01))
    else $error("normalize step wrong");

  // normalizing ends within 63 shifts
  AST_NORM_BOUND: assert property ((state_r == ST_NEG) |=> ##[1:64] (state_r == ST_ROUND))
    else $error("normalize did not finish");

  // nearest even decision
  AST_NEAR_EVEN: assert property (fin_round && (mode_r == 2'h0) |->
    rnd_inc == (frac_r[10] & (frac_r[11] | frac_r[9] | (|frac_r[8:0]))))
    else $error("nearest even increment wrong");

  // round toward plus
  AST_ROUND_UP: assert property (fin_round && (mode_r == 2'h2) |->
    rnd_inc == (!sign_r && (|frac_r[10:0])))
    else $error("round up increment wrong");

  // round toward minus
  AST_ROUND_DOWN: assert property (fin_round && (mode_r == 2'h3) |->
    rnd_inc == (sign_r && (|frac_r[10:0])))
    else $error("round down increment wrong");

  // toward zero never increments
  AST_TRUNC: assert property (fin_round && (mode_r == 2'h1) |=> !rounded_r)
    else $error("truncation incremented");

  // flags follow the rounding step
  AST_FLAGS: assert property (fin_round |=>
    (rounded_r == $past(rnd_inc)) && (inexact_r == $past(|frac_r[10:0])))
    else $error("rounded or inexact flag wrong");

  // sticky inexact only falls by a software write
  AST_STICKY: assert property (sticky_r && !(reg_wr && sel_fstat) |=> sticky_r)
    else $error("sticky inexact lost");

  // inexact result raises the sticky bit
  AST_STICKY_SET: assert property (fin_round && rnd_inx |=> sticky_r)
    else $error("sticky inexact not set");

  // class of a nonzero result
  AST_CLASS: assert property (fin_round |=>
    (rclass_r == ($past(sign_r) ? 5'h08 : 5'h04)))
    else $error("result class wrong");

  // packing of sign and biased exponent, with carry
  AST_PACK: assert property (fin_round |=>
    (res_r[63] == $past(sign_r)) && (res_r[62:52] == {4'h0, $past(exp_r)} + 11'h3ff + {10'h0, $past(rnd_carry)}))
    else $error("result packing wrong");

endmodule

// ### src/itd_defines.svh
`ifndef ITD_DEFINES_SVH
`define ITD_DEFINES_SVH

// ----------------------------------------------------------------------------
// register offsets (byte addresses, one aligned 32-bit word each)
// ----------------------------------------------------------------------------
`define ITD_OFS_SRC_LO 8'h00
`define ITD_OFS_SRC_HI 8'h04
`define ITD_OFS_CMD 8'h08
`define ITD_OFS_FSTAT 8'h0c
`define ITD_OFS_RES_LO 8'h10
`define ITD_OFS_RES_HI 8'h14
`define ITD_OFS_STATUS 8'h18
`define ITD_OFS_INT_STAT 8'h1c
`define ITD_OFS_INT_MASK 8'h20

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define ITD_CMD_START 0
`define ITD_STATUS_BUSY 0
`define ITD_FSTAT_RND_LO 0
`define ITD_FSTAT_RND_HI 1
`define ITD_FSTAT_ROUNDED 2
`define ITD_FSTAT_INEXACT 3
`define ITD_FSTAT_STICKY 4
`define ITD_FSTAT_CLASS_LO 5
`define ITD_FSTAT_CLASS_HI 9
`define ITD_INT_DONE 0
`define ITD_INT_INEXACT 1

// working fraction positions (bit 63 is the leading bit)
`define ITD_LSB_POS 11
`define ITD_GUARD_POS 10
`define ITD_ROUND_POS 9
`define ITD_STICKY_HI 8

// ----------------------------------------------------------------------------
// reset values and constants
// ----------------------------------------------------------------------------
`define ITD_RND_RST 2'h0
`define ITD_INT_MASK_RST 2'h0
`define ITD_CLASS_RST 5'h00
`define ITD_EXP_INIT 7'h3f
`define ITD_EXP_BIAS 11'h3ff
`define ITD_CLASS_PZERO 5'h02
`define ITD_CLASS_PNORM 5'h04
`define ITD_CLASS_NNORM 5'h08
`define ITD_RND_NEAR 2'h0
`define ITD_RND_ZERO 2'h1
`define ITD_RND_UP 2'h2
`define ITD_RND_DOWN 2'h3

`endif

// ### src/itd_norm_step.sv
`timescale 1ns/1ps
`include "itd_defines.svh"

module itd_norm_step (
  input wire itd_pkg::itd_frac_t frac_in, // working fraction
  input wire itd_pkg::itd_exp_t exp_in, // working exponent
  output itd_pkg::itd_frac_t frac_out, // fraction after one step
  output itd_pkg::itd_exp_t exp_out, // exponent after one step
  output logic normalized // leading bit already set
);
  import itd_pkg::*;

  // one left shift per step until the leading bit is one
  assign normalized = frac_in[63];
  assign frac_out = normalized ? frac_in : {frac_in[62:0], 1'b0};
  assign exp_out = normalized ? exp_in : exp_in - 7'h01;

endmodule

// ### src/itd_pkg.sv
package itd_pkg;

  typedef logic [7:0] itd_addr_t;
  typedef logic [31:0] itd_word_t;
  typedef logic [63:0] itd_frac_t;
  typedef logic [6:0] itd_exp_t;
  typedef logic [1:0] itd_mode_t;
  typedef logic [4:0] itd_class_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOAD,
    ST_NEG,
    ST_NORM,
    ST_ROUND
  } itd_state_e;

endpackage

// ### src/itd_round.sv
`timescale 1ns/1ps
`include "itd_defines.svh"

module itd_round (
  input wire itd_pkg::itd_frac_t frac, // normalized fraction
  input wire logic sign, // operand sign
  input wire itd_pkg::itd_mode_t mode, // rounding control
  output logic inc, // increment applied
  output logic [52:0] kept, // 53 kept bits after increment
  output logic carry, // carry out of the kept bits
  output logic inexact // any bit dropped
);
  import itd_pkg::*;

  logic lsb;
  logic gbit;
  logic rbit;
  logic xbit;
  logic any_lost;
  logic inc_near;
  logic inc_up;
  logic inc_down;
  logic [53:0] sum;

  // pick the kept lsb, guard, round and sticky bits
  assign lsb = frac[`ITD_LSB_POS];
  assign gbit = frac[`ITD_GUARD_POS];
  assign rbit = frac[`ITD_ROUND_POS];
  assign xbit = |frac[`ITD_STICKY_HI:0];
  assign any_lost = gbit | rbit | xbit;

  // increment decision per mode
  assign inc_near = gbit & (lsb | rbit | xbit);
  assign inc_up = ~sign & any_lost;
  assign inc_down = sign & any_lost;
  assign inc = (mode == `ITD_RND_NEAR) ? inc_near :
               (mode == `ITD_RND_UP) ? inc_up :
               (mode == `ITD_RND_DOWN) ? inc_down : 1'b0;

  // add into the top 53 bits, carry bumps the exponent outside
  assign sum = {1'b0, frac[63:`ITD_LSB_POS]} + {53'h0, inc};
  assign kept = sum[52:0];
  assign carry = sum[53];
  assign inexact = any_lost;

endmodule

// ### test/tb_top.sv
`timescale 1ns/1ps
`include "itd_defines.svh"

module tb_top;
  import itd_pkg::*;

  logic clk;
  logic sys_rst;
  itd_addr_t reg_addr;
  itd_word_t reg_wdata;
  logic reg_wr;
  logic reg_rd;
  itd_word_t reg_rdata;
  logic irq;
  logic want;
  logic pend;
  logic sticky_m;
  int n_w;
  itd_word_t exp_q[$];
  itd_word_t exp_w;
  int fail_count;
  int n_tests;
  int cyc;
  logic [63:0] vec[9] = '{64'h0, 64'h1, 64'hffff_ffff_ffff_ffff, 64'h8000_0000_0000_0000,
    64'h7fff_ffff_ffff_ffff, 64'h7fff_ffff_ffff_fa00, 64'h7fff_ffff_ffff_fe00,
    64'h8000_0000_0000_0600, 64'h0020_0000_0000_0001};

  itd_convert DUT (
    .clk(clk),
    .sys_rst(sys_rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .irq(irq)
  );

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  task automatic fail(input string m);
    fail_count++;
    $display("[FAIL] %0t %s", $time, m);
  endtask

  task automatic chk(input logic g, input logic e, input string m);
    n_tests++;
    if (g !== e)
      fail(m);
  endtask

  task automatic print_verdict();
    $display("errors %0d checks %0d", fail_count, n_tests);
    if (fail_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // one-cycle write strobe
  task automatic wr(input itd_addr_t a, input itd_word_t d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // one-cycle read strobe, expected word noted for the monitor
  task automatic rd(input itd_addr_t a, input itd_word_t e);
    exp_q.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    want <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    want <= 1'b0;
  endtask

  // read whose value the driver itself needs (busy polling)
  task automatic rd_raw(input itd_addr_t a, output itd_word_t d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // reference conversion worked out bit by bit
  function automatic void model(input logic [63:0] s, input logic [1:0] m, output logic [63:0] res,
                                output logic rnd, output logic inx, output logic [4:0] cls, output int lat);
    logic sg;
    logic [63:0] f;
    logic [10:0] e;
    logic g;
    logic r;
    logic x;
    logic l;
    logic inc;
    logic [53:0] k;
    sg = s[63];
    f = sg ? ~s + 64'h1 : s;
    e = `ITD_EXP_BIAS + 11'h03f;
    res = 64'h0;
    rnd = 1'b0;
    inx = 1'b0;
    cls = `ITD_CLASS_PZERO;
    lat = 1;
    if (s == 64'h0)
      return;
    lat = 4;
    while (!f[63])
    begin
      f = f << 1;
      e = e - 11'h001;
      lat++;
    end
    l = f[11];
    g = f[10];
    r = f[9];
    x = |f[8:0];
    case (m)
      `ITD_RND_NEAR: inc = g & (l | r | x);
      `ITD_RND_ZERO: inc = 1'b0;
      `ITD_RND_UP: inc = !sg & (g | r | x);
      default: inc = sg & (g | r | x);
    endcase
    k = {1'b0, f[63:11]} + {53'h0, inc};
    if (k[53])
      e = e + 11'h001;
    res = {sg, e, k[51:0]};
    rnd = inc;
    inx = g | r | x;
    cls = sg ? `ITD_CLASS_NNORM : `ITD_CLASS_PNORM;
  endfunction

  // wait for the interrupt under a bound, counting edges from the start edge
  task automatic wait_irq(output int n);
    n = 0;
    while (irq !== 1'b1 && n < 100)
    begin
      @(posedge clk);
      #1 n++;
    end
  endtask

  // full conversion: load, start, wait, then check result, flags and events
  task automatic conv(input logic [63:0] s, input logic [1:0] m, input bit poll);
    logic [63:0] res;
    logic rnd;
    logic inx;
    logic [4:0] cls;
    int lat;
    int n;
    itd_word_t st;
    model(s, m, res, rnd, inx, cls, lat);
    wr(`ITD_OFS_SRC_LO, s[31:0]);
    wr(`ITD_OFS_SRC_HI, s[63:32]);
    wr(`ITD_OFS_FSTAT, {27'h0, sticky_m, 2'h0, m});
    wr(`ITD_OFS_CMD, 32'h1);
    if (poll)
    begin
      st = 32'h1;
      n = 0;
      while (st[0] !== 1'b0 && n < 40)
      begin
        rd_raw(`ITD_OFS_STATUS, st);
        n++;
      end
      chk(st[0], 1'b0, "busy never cleared");
    end
    else
    begin
      wait_irq(n);
      chk(n == lat, 1'b1, "conversion latency");
    end
    sticky_m = sticky_m | inx;
    rd(`ITD_OFS_RES_LO, res[31:0]);
    rd(`ITD_OFS_RES_HI, res[63:32]);
    rd(`ITD_OFS_FSTAT, {22'h0, cls, sticky_m, inx, rnd, m});
    rd(`ITD_OFS_INT_STAT, {30'h0, inx, 1'b1});
    if (poll)
    begin
      chk(irq, 1'b0, "masked event raised irq");
      wr(`ITD_OFS_INT_MASK, 32'h3);
      @(posedge clk);
      #1 chk(irq, 1'b1, "unmasked event gave no irq");
    end
    wr(`ITD_OFS_INT_STAT, 32'h3);
    @(posedge clk);
    #1 chk(irq, 1'b0, "irq not cleared");
  endtask

  // ----------------------------------------------------------------------------
  // clock, timeout and read monitor
  // ----------------------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // cut a hang short
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      fail("timeout");
      print_verdict();
    end
  end

  // compares each read word from rd (not rd_raw) with the oldest note
  always @(posedge clk)
  begin
    if (pend)
    begin
      if (exp_q.size() == 0)
        fail("read without a note");
      else
      begin
        exp_w = exp_q.pop_front();
        n_tests++;
        if (reg_rdata !== exp_w)
          fail($sformatf("rdata %h expected %h", reg_rdata, exp_w));
      end
    end
    pend = reg_rd & want;
  end

  // ----------------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------------
  initial
  begin
    logic [63:0] s;
    sys_rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    want = 1'b0;
    pend = 1'b0;
    sticky_m = 1'b0;
    void'($urandom(42317));
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    // reset values, command word and unmapped place read zero
    for (int a = 0; a <= 36; a += 4)
      rd(8'(a), 32'h0);
    wr(8'h24, 32'hffff_ffff);
    rd(8'h24, 32'h0);
    wr(`ITD_OFS_RES_LO, 32'hffff_ffff);
    rd(`ITD_OFS_RES_LO, 32'h0);
    wr(`ITD_OFS_INT_MASK, 32'hffff_ffff);
    rd(`ITD_OFS_INT_MASK, 32'h3);
    // every directed operand under every rounding mode
    foreach (vec[i])
      for (int m = 0; m < 4; m++)
        conv(vec[i], 2'(m), 1'b0);
    // software clears the sticky bit, then a masked conversion
    sticky_m = 1'b0;
    wr(`ITD_OFS_INT_MASK, 32'h0);
    conv(64'h7fff_ffff_ffff_fa00, `ITD_RND_UP, 1'b1);
    // start while busy is ignored; source change after load has no effect
    wr(`ITD_OFS_SRC_LO, 32'h1);
    wr(`ITD_OFS_SRC_HI, 32'h0);
    wr(`ITD_OFS_CMD, 32'h1);
    wr(`ITD_OFS_SRC_LO, 32'h5);
    wr(`ITD_OFS_CMD, 32'h1);
    wait_irq(n_w);
    chk(n_w == 63, 1'b1, "refused start changed the latency");
    rd(`ITD_OFS_RES_HI, 32'h3ff0_0000);
    rd(`ITD_OFS_RES_LO, 32'h0);
    wr(`ITD_OFS_INT_STAT, 32'h3);
    // random operands with random leading zeros, sign and mode
    for (int i = 0; i < 24; i++)
    begin
      s = {$urandom, $urandom} >> ($urandom % 64);
      if ($urandom % 2)
        s = -s;
      conv(s, 2'($urandom % 4), 1'b0);
    end
    print_verdict();
  end

endmodule
